// ---- ssb_defines.svh ----
`ifndef SSB_DEFINES_SVH
`define SSB_DEFINES_SVH

// Sensor register addresses
`define SSB_A_VARIANT 9'h002
`define SSB_A_CLKMGT 9'h020
`define SSB_A_LOGIC_EN 9'h022
`define SSB_A_COLMUX_EN 9'h028
`define SSB_A_AFE_EN 9'h030
`define SSB_A_BIAS_EN 9'h040
`define SSB_A_GEN_BIAS 9'h041
`define SSB_A_AFE_BIAS 9'h042
`define SSB_A_MUX_BIAS 9'h043
`define SSB_A_SER_BIAS 9'h044
`define SSB_A_SER_TX_EN 9'h070
`define SSB_A_BLACK 9'h080
`define SSB_A_WDEPTH 9'h081
`define SSB_A_SEQ_MODE 9'h0c0
`define SSB_A_GAIN 9'h0cc
`define SSB_A_DUMMY_ROWS 9'h0e0
`define SSB_A_LATENCY 9'h0e1
`define SSB_A_SEQ_CFG_A 9'h1bf
`define SSB_A_SEQ_CFG_B 9'h1c0
`define SSB_STBY1_LIMIT 9'h028

// Upload values
`define SSB_V_CLK_CFG 16'h2002
`define SSB_V_LOGIC_ON 16'h0001
`define SSB_V_GEN_BIAS 16'h008b
`define SSB_V_AFE_BIAS 16'h53c6
`define SSB_V_MUX_BIAS 16'h0844
`define SSB_V_SER_BIAS 16'h0086
`define SSB_V_BLACK 16'h4520
`define SSB_V_GAIN 16'h09e5
`define SSB_V_DUMMY_ROWS 16'h3e04
`define SSB_V_LATENCY 16'h6733
`define SSB_V_SEQ_CFG_A 16'h0bf1
`define SSB_V_SEQ_CFG_B 16'h0bc3
`define SSB_V_CLK_ANALOG 16'h2003
`define SSB_V_BIAS_ON 16'h0001
`define SSB_V_COLMUX_ON 16'h0003
`define SSB_V_AFE_ON 16'h0001
`define SSB_V_SER_TX_ON 16'h0007

// Field positions
`define SSB_WDEPTH_BIT 13
`define SSB_SEQ_EN_BIT 0
`define SSB_SHUTTER_BIT 1
`define SSB_TRIG_BIT 4
`define SSB_SLAVE_BIT 5
`define SSB_SUBSAMP_BIT 7
`define SSB_BINNING_BIT 8
`define SSB_MODE_MASK 16'h01b2
`define SSB_UPLOAD_LAST 5'h13

// Timing
`define SSB_CLK_NS 25
`define SSB_RST_WAIT_US 10
`define SSB_RST_WAIT_CYC ((`SSB_RST_WAIT_US * 1000 + `SSB_CLK_NS - 1) / `SSB_CLK_NS)
`define SSB_CLK_SETTLE_CYC 16

// Controller register map (AXI4-Lite byte offsets)
`define SSB_R_CTRL 4'h0
`define SSB_R_MODE 4'h4
`define SSB_R_STATUS 4'h8
`define SSB_CTRL_START 0
`define SSB_CTRL_SEQ 1
`define SSB_CTRL_COLOR 2
`define SSB_CTRL_WORD8 3
`define SSB_RESP_OKAY 2'b00
`define SSB_RESP_SLVERR 2'b10

`endif

// ---- ssb_pkg.sv ----
package ssb_pkg;

	typedef enum logic [2:0] {
		DS_OFF,
		DS_STBY1,
		DS_STBY_INT,
		DS_STBY2,
		DS_IDLE,
		DS_RUN
	} ssb_dev_state_t;

	typedef enum logic [2:0] {
		HS_OFF,
		HS_CLK,
		HS_RWAIT,
		HS_LOAD,
		HS_READY,
		HS_RD,
		HS_WR
	} ssb_host_state_t;

	typedef struct packed {
		ssb_dev_state_t st;
		logic [18:0][15:0] regs;
		logic run;
		logic ack;
		logic err;
		logic [15:0] rdata;
	} ssb_dev_s_t;

	typedef struct packed {
		ssb_host_state_t st;
		logic [15:0] cnt;
		logic [4:0] step;
		logic clk_en;
		logic rst_n;
		logic req;
		logic wr;
		logic [8:0] addr;
		logic [15:0] wdata;
		logic done;
		logic err;
		logic seq_on;
		logic seq_req;
		logic color;
		logic word8;
		logic [15:0] mode;
		logic aw_have;
		logic [3:0] aw_addr;
		logic w_have;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} ssb_host_s_t;

endpackage : ssb_pkg

// ---- ssb_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface ssb_if;
	logic sens_clk_en;
	logic sens_rst_n;
	logic req;
	logic wr;
	logic [8:0] addr;
	logic [15:0] wdata;
	logic ack;
	logic err;
	logic [15:0] rdata;
	ssb_pkg::ssb_dev_state_t state;

	modport dev (
		input sens_clk_en,
		input sens_rst_n,
		input req,
		input wr,
		input addr,
		input wdata,
		output ack,
		output err,
		output rdata,
		output state
	);

	modport host (
		output sens_clk_en,
		output sens_rst_n,
		output req,
		output wr,
		output addr,
		output wdata,
		input ack,
		input err,
		input rdata,
		input state
	);
endinterface : ssb_if
`default_nettype wire

// ---- ssb_upload_rom.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ssb_defines.svh"
module ssb_upload_rom (
	input wire logic [4:0] step,
	input wire logic color,
	input wire logic word8,
	input wire logic [15:0] mode,
	output logic [8:0] addr,
	output logic [15:0] data,
	output logic last
);
	always_comb begin
		last = (step == `SSB_UPLOAD_LAST);
		addr = `SSB_A_SEQ_MODE;
		data = mode & `SSB_MODE_MASK;
		case (step)
			5'h00: begin addr = `SSB_A_VARIANT; data = {15'h0000, color}; end
			5'h01: begin addr = `SSB_A_CLKMGT; data = `SSB_V_CLK_CFG; end
			5'h02: begin addr = `SSB_A_LOGIC_EN; data = `SSB_V_LOGIC_ON; end
			5'h03: begin addr = `SSB_A_GEN_BIAS; data = `SSB_V_GEN_BIAS; end
			5'h04: begin addr = `SSB_A_AFE_BIAS; data = `SSB_V_AFE_BIAS; end
			5'h05: begin addr = `SSB_A_MUX_BIAS; data = `SSB_V_MUX_BIAS; end
			5'h06: begin addr = `SSB_A_SER_BIAS; data = `SSB_V_SER_BIAS; end
			5'h07: begin addr = `SSB_A_BLACK; data = `SSB_V_BLACK; end
			5'h08: begin addr = `SSB_A_GAIN; data = `SSB_V_GAIN; end
			5'h09: begin addr = `SSB_A_DUMMY_ROWS; data = `SSB_V_DUMMY_ROWS; end
			5'h0a: begin addr = `SSB_A_LATENCY; data = `SSB_V_LATENCY; end
			5'h0b: begin addr = `SSB_A_WDEPTH; data = 16'(word8) << `SSB_WDEPTH_BIT; end
			5'h0c: begin addr = `SSB_A_SEQ_CFG_A; data = `SSB_V_SEQ_CFG_A; end
			5'h0d: begin addr = `SSB_A_SEQ_CFG_B; data = `SSB_V_SEQ_CFG_B; end
			5'h0e: begin addr = `SSB_A_CLKMGT; data = `SSB_V_CLK_ANALOG; end
			5'h0f: begin addr = `SSB_A_BIAS_EN; data = `SSB_V_BIAS_ON; end
			5'h10: begin addr = `SSB_A_COLMUX_EN; data = `SSB_V_COLMUX_ON; end
			5'h11: begin addr = `SSB_A_AFE_EN; data = `SSB_V_AFE_ON; end
			5'h12: begin addr = `SSB_A_SER_TX_EN; data = `SSB_V_SER_TX_ON; end
			default: begin addr = `SSB_A_SEQ_MODE; data = mode & `SSB_MODE_MASK; end
		endcase
	end
endmodule : ssb_upload_rom
`default_nettype wire

// ---- ssb_device.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ssb_defines.svh"
module ssb_device (
	input wire logic aclk,
	input wire logic aresetn,
	ssb_if.dev lk,
	output logic [2:0] dev_state,
	output logic acquiring,
	output logic shutter_rolling,
	output logic triggered,
	output logic slave,
	output logic subsample,
	output logic binning,
	output logic word8
);
	ssb_pkg::ssb_dev_s_t s;
	ssb_pkg::ssb_dev_s_t n;

	function automatic logic [4:0] reg_idx(input logic [8:0] a);
		case (a)
			`SSB_A_VARIANT: reg_idx = 5'h00;
			`SSB_A_CLKMGT: reg_idx = 5'h01;
			`SSB_A_LOGIC_EN: reg_idx = 5'h02;
			`SSB_A_COLMUX_EN: reg_idx = 5'h03;
			`SSB_A_AFE_EN: reg_idx = 5'h04;
			`SSB_A_BIAS_EN: reg_idx = 5'h05;
			`SSB_A_GEN_BIAS: reg_idx = 5'h06;
			`SSB_A_AFE_BIAS: reg_idx = 5'h07;
			`SSB_A_MUX_BIAS: reg_idx = 5'h08;
			`SSB_A_SER_BIAS: reg_idx = 5'h09;
			`SSB_A_SER_TX_EN: reg_idx = 5'h0a;
			`SSB_A_BLACK: reg_idx = 5'h0b;
			`SSB_A_WDEPTH: reg_idx = 5'h0c;
			`SSB_A_SEQ_MODE: reg_idx = 5'h0d;
			`SSB_A_GAIN: reg_idx = 5'h0e;
			`SSB_A_DUMMY_ROWS: reg_idx = 5'h0f;
			`SSB_A_LATENCY: reg_idx = 5'h10;
			`SSB_A_SEQ_CFG_A: reg_idx = 5'h11;
			`SSB_A_SEQ_CFG_B: reg_idx = 5'h12;
			default: reg_idx = 5'h1f;
		endcase
	endfunction : reg_idx

	function automatic logic [15:0] rv(input ssb_pkg::ssb_dev_s_t st, input logic [8:0] a);
		rv = st.regs[reg_idx(a)];
	endfunction : rv

	logic clk_ok;
	logic rsv_ok;
	logic pwr_ok;
	logic [4:0] idx;
	logic allowed;

	// Actions are recognised from the register contents alone
	assign clk_ok = rv(s, `SSB_A_CLKMGT) == `SSB_V_CLK_CFG && rv(s, `SSB_A_LOGIC_EN) == `SSB_V_LOGIC_ON;
	assign rsv_ok = rv(s, `SSB_A_GEN_BIAS) == `SSB_V_GEN_BIAS && rv(s, `SSB_A_AFE_BIAS) == `SSB_V_AFE_BIAS
		&& rv(s, `SSB_A_MUX_BIAS) == `SSB_V_MUX_BIAS && rv(s, `SSB_A_SER_BIAS) == `SSB_V_SER_BIAS
		&& rv(s, `SSB_A_BLACK) == `SSB_V_BLACK && rv(s, `SSB_A_GAIN) == `SSB_V_GAIN
		&& rv(s, `SSB_A_DUMMY_ROWS) == `SSB_V_DUMMY_ROWS && rv(s, `SSB_A_LATENCY) == `SSB_V_LATENCY
		&& rv(s, `SSB_A_SEQ_CFG_A) == `SSB_V_SEQ_CFG_A && rv(s, `SSB_A_SEQ_CFG_B) == `SSB_V_SEQ_CFG_B;
	assign pwr_ok = rv(s, `SSB_A_CLKMGT) == `SSB_V_CLK_ANALOG && rv(s, `SSB_A_BIAS_EN) == `SSB_V_BIAS_ON
		&& rv(s, `SSB_A_COLMUX_EN) == `SSB_V_COLMUX_ON && rv(s, `SSB_A_AFE_EN) == `SSB_V_AFE_ON
		&& rv(s, `SSB_A_SER_TX_EN) == `SSB_V_SER_TX_ON;
	assign idx = reg_idx(lk.addr);
	assign allowed = (s.st != ssb_pkg::DS_STBY1) || (lk.addr < `SSB_STBY1_LIMIT);

	always_comb begin
		n = s;
		n.ack = 1'b0;
		n.err = 1'b0;
		if (!lk.sens_clk_en || !lk.sens_rst_n) begin
			n = '0;
			n.st = ssb_pkg::DS_OFF;
		end else begin
			if (lk.req && !s.ack) begin
				n.ack = 1'b1;
				if (idx == 5'h1f || !allowed || s.st == ssb_pkg::DS_OFF) begin
					n.err = 1'b1;
				end else if (lk.wr) begin
					n.regs[idx] = lk.wdata;
				end else begin
					n.rdata = s.regs[idx];
				end
			end
			unique case (s.st)
				ssb_pkg::DS_OFF: n.st = ssb_pkg::DS_STBY1;
				ssb_pkg::DS_STBY1: if (clk_ok) n.st = ssb_pkg::DS_STBY_INT;
				ssb_pkg::DS_STBY_INT: if (rsv_ok) n.st = ssb_pkg::DS_STBY2;
				ssb_pkg::DS_STBY2: if (pwr_ok) n.st = ssb_pkg::DS_IDLE;
				ssb_pkg::DS_IDLE: if (s.regs[5'h0d][`SSB_SEQ_EN_BIT]) n.st = ssb_pkg::DS_RUN;
				ssb_pkg::DS_RUN: if (!s.regs[5'h0d][`SSB_SEQ_EN_BIT]) n.st = ssb_pkg::DS_IDLE;
			endcase
		end
		n.run = (n.st == ssb_pkg::DS_RUN);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign lk.ack = s.ack;
	assign lk.err = s.err;
	assign lk.rdata = s.rdata;
	assign lk.state = s.st;
	assign dev_state = s.st;
	assign acquiring = s.run;
	assign shutter_rolling = s.regs[5'h0d][`SSB_SHUTTER_BIT];
	assign triggered = s.regs[5'h0d][`SSB_TRIG_BIT];
	assign slave = s.regs[5'h0d][`SSB_SLAVE_BIT];
	assign subsample = s.regs[5'h0d][`SSB_SUBSAMP_BIT];
	assign binning = s.regs[5'h0d][`SSB_BINNING_BIT];
	assign word8 = s.regs[5'h0c][`SSB_WDEPTH_BIT];
endmodule : ssb_device
`default_nettype wire

// ---- ssb_host.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ssb_defines.svh"
// What this block does
// - Six states ranked by power dissipation
// - Standby one accepts only addresses below 40
// - Standby two opens every register
// - Reserved uploads lead from intermediate standby
// - Idle runs everything except the sequencer
// - Running acquires in selected shutter mode
// - Transitions happen only through register writes; the device model moves from off to standby one without a write
// - Start clock, then release hard reset
// - Wait 10 us after reset release
// - Input clock 248 or 310 MHz
// - Clock management uploads in strict order
// - Bias registers take exact values
// - Black level register takes fixed value
// - Gain, dummy rows and latency values
// - Bit 13 of 129 selects word depth
// - Sequencer configuration uploads come last
// - Soft power-up uploads in order
// - Set sequencer bit, keep other bits
// - Clear sequencer bit, return to idle
// - Mode bits of register 192
module ssb_host #(
	parameter int RST_WAIT = `SSB_RST_WAIT_CYC,
	parameter int CLK_SETTLE = `SSB_CLK_SETTLE_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	ssb_if.host lk,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	ssb_pkg::ssb_host_s_t s;
	ssb_pkg::ssb_host_s_t n;
	logic [8:0] rom_addr;
	logic [15:0] rom_data;
	logic rom_last;

	ssb_upload_rom u_rom (
		.step(s.step),
		.color(s.color),
		.word8(s.word8),
		.mode(s.mode),
		.addr(rom_addr),
		.data(rom_data),
		.last(rom_last)
	);

	always_comb begin
		n = s;
		// Register port: address and data are taken in either order
		if (s_axi_awvalid && s.awready) begin
			n.aw_have = 1'b1;
			n.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s.wready) begin
			n.w_have = 1'b1;
			n.w_data = s_axi_wdata;
			// Strobes belong to the data beat, so keep them with it
			n.w_strb = s_axi_wstrb;
		end
		if (s.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end
		if (s.aw_have && s.w_have && !s.bvalid) begin
			n.aw_have = 1'b0;
			n.w_have = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = `SSB_RESP_OKAY;
			case (s.aw_addr)
				`SSB_R_CTRL: if (s.w_strb[0]) begin
					n.seq_req = s.w_data[`SSB_CTRL_SEQ];
					n.color = s.w_data[`SSB_CTRL_COLOR];
					n.word8 = s.w_data[`SSB_CTRL_WORD8];
					if (s.w_data[`SSB_CTRL_START] && s.st == ssb_pkg::HS_OFF) begin
						n.st = ssb_pkg::HS_CLK;
						n.clk_en = 1'b1;
						n.cnt = 16'(CLK_SETTLE);
					end
				end
				`SSB_R_MODE: begin
					if (s.w_strb[0]) n.mode[7:0] = 8'(s.w_data[15:0] & `SSB_MODE_MASK);
					if (s.w_strb[1]) n.mode[15:8] = 8'((s.w_data[15:0] & `SSB_MODE_MASK) >> 8);
				end
				`SSB_R_STATUS: n.bresp = `SSB_RESP_OKAY;
				default: n.bresp = `SSB_RESP_SLVERR;
			endcase
		end
		if (s.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s.arready) begin
			n.rvalid = 1'b1;
			n.rresp = `SSB_RESP_OKAY;
			case (s_axi_araddr)
				`SSB_R_CTRL: n.rdata = {28'h0000000, s.word8, s.color, s.seq_req, 1'b0};
				`SSB_R_MODE: n.rdata = {16'h0000, s.mode};
				`SSB_R_STATUS: n.rdata = {24'h000000, s.err, s.done, 3'(lk.state), 3'(s.st)};
				default: begin
					n.rdata = 32'h00000000;
					n.rresp = `SSB_RESP_SLVERR;
				end
			endcase
		end
		n.awready = !n.aw_have;
		n.wready = !n.w_have;
		n.arready = !n.rvalid;

		// Bring-up and sequencer control
		if (s.req && lk.ack) begin
			n.req = 1'b0;
			if (lk.err) n.err = 1'b1;
		end
		unique case (s.st)
			ssb_pkg::HS_OFF: n.rst_n = 1'b0;
			ssb_pkg::HS_CLK: begin
				if (s.cnt != 16'h0000) begin
					n.cnt = s.cnt - 16'h0001;
				end else begin
					n.rst_n = 1'b1;
					n.cnt = 16'(RST_WAIT);
					n.st = ssb_pkg::HS_RWAIT;
				end
			end
			ssb_pkg::HS_RWAIT: begin
				if (s.cnt != 16'h0000) n.cnt = s.cnt - 16'h0001;
				else n.st = ssb_pkg::HS_LOAD;
			end
			ssb_pkg::HS_LOAD: begin
				if (!s.req) begin
					n.req = 1'b1;
					n.wr = 1'b1;
					n.addr = rom_addr;
					n.wdata = rom_data;
				end else if (lk.ack) begin
					if (rom_last) begin
						n.st = ssb_pkg::HS_READY;
						n.done = 1'b1;
					end else begin
						n.step = s.step + 5'h01;
					end
				end
			end
			ssb_pkg::HS_READY: begin
				if (s.seq_req != s.seq_on) begin
					n.st = ssb_pkg::HS_RD;
					n.req = 1'b1;
					n.wr = 1'b0;
					n.addr = `SSB_A_SEQ_MODE;
				end
			end
			ssb_pkg::HS_RD: begin
				if (lk.ack) begin
					n.st = ssb_pkg::HS_WR;
					n.wdata = lk.rdata;
					n.wdata[`SSB_SEQ_EN_BIT] = s.seq_req;
				end
			end
			ssb_pkg::HS_WR: begin
				if (!s.req) begin
					n.req = 1'b1;
					n.wr = 1'b1;
				end else if (lk.ack) begin
					n.seq_on = s.wdata[`SSB_SEQ_EN_BIT];
					n.st = ssb_pkg::HS_READY;
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign lk.sens_clk_en = s.clk_en;
	assign lk.sens_rst_n = s.rst_n;
	assign lk.req = s.req;
	assign lk.wr = s.wr;
	assign lk.addr = s.addr;
	assign lk.wdata = s.wdata;
	assign s_axi_awready = s.awready;
	assign s_axi_wready = s.wready;
	assign s_axi_bresp = s.bresp;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_arready = s.arready;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;
	assign s_axi_rvalid = s.rvalid;
endmodule : ssb_host
`default_nettype wire

// ---- ssb_link_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module ssb_link_assertions #(
	parameter int RST_WAIT = 400
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic sens_clk_en,
	input wire logic sens_rst_n,
	input wire logic req,
	input wire logic wr,
	input wire logic [8:0] addr,
	input wire logic [15:0] wdata,
	input wire logic ack,
	input wire logic err,
	input wire logic [15:0] rdata,
	input wire ssb_pkg::ssb_dev_state_t state
);
	// Cycles since the sensor left hard reset, saturating
	logic [15:0] since_r;
	logic [15:0] since_nxt;
	always_comb begin
		since_nxt = (since_r == 16'hffff) ? since_r : since_r + 16'h0001;
		if (!sens_rst_n)
			since_nxt = 16'h0000;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn)
			since_r <= 16'h0000;
		else
			since_r <= since_nxt;
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_ack_follows_req: assert property (req && !ack |=> ack) else $error("no ack after request");
	a_ack_one_pulse: assert property (ack |=> !ack) else $error("ack longer than one cycle");
	a_err_with_ack: assert property (err |-> ack) else $error("err without ack");
	a_stby1_refuse: assert property (state == ssb_pkg::DS_STBY1 && req && !ack && addr >= 9'h028 |=> err)
		else $error("high address accepted in standby one");
	a_held_off: assert property (!(sens_rst_n && sens_clk_en) |=> state == ssb_pkg::DS_OFF)
		else $error("state not off under hard reset");
	a_enter_stby1: assert property (state == ssb_pkg::DS_OFF && sens_rst_n && sens_clk_en
		|=> state == ssb_pkg::DS_STBY1) else $error("standby one not entered");
	a_clock_first: assert property ($rose(sens_rst_n) |-> $past(sens_clk_en))
		else $error("reset released before clock");
	a_reset_wait: assert property (req && sens_rst_n |-> since_r >= RST_WAIT)
		else $error("request too soon after reset release");
	a_stby2_order: assert property (state == ssb_pkg::DS_STBY2 && $past(state) != ssb_pkg::DS_STBY2
		|-> $past(state) == ssb_pkg::DS_STBY_INT) else $error("standby two not via intermediate");
	a_run_from_idle: assert property ($changed(state) && state == ssb_pkg::DS_RUN
		|-> $past(state) == ssb_pkg::DS_IDLE) else $error("running not entered from idle");
	a_state_by_write: assert property ($changed(state) && sens_rst_n && sens_clk_en && $past(sens_rst_n)
		&& $past(state) != ssb_pkg::DS_OFF |-> ack || $past(ack) || $past(ack, 2))
		else $error("state moved without a write");
endmodule : ssb_link_assertions
`default_nettype wire

// ---- sensor_state_bringup_sequencer_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ssb_defines.svh"
module sensor_state_bringup_sequencer_test;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [3:0] awaddr = 4'h0;
	logic awvalid = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic [3:0] araddr = 4'h0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [2:0] dev_state;
	logic acquiring, shutter_rolling, triggered, slave, subsample, binning, word8;
	logic [31:0] seed = 32'h00000032;
	logic [31:0] st;
	logic [1:0] rs;
	logic [15:0] mode;
	logic col, w8;
	int error_cnt = 0;
	int checked = 0;
	ssb_if lk();
	ssb_host #(.RST_WAIT(8), .CLK_SETTLE(2)) u_ssb_host (.aclk(aclk), .aresetn(aresetn), .lk(lk),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));
	ssb_device u_ssb_device (.aclk(aclk), .aresetn(aresetn), .lk(lk), .dev_state(dev_state),
		.acquiring(acquiring), .shutter_rolling(shutter_rolling), .triggered(triggered), .slave(slave),
		.subsample(subsample), .binning(binning), .word8(word8));
	ssb_link_assertions #(.RST_WAIT(8)) u_ssb_link_assertions (.aclk(aclk), .aresetn(aresetn),
		.sens_clk_en(lk.sens_clk_en), .sens_rst_n(lk.sens_rst_n), .req(lk.req), .wr(lk.wr), .addr(lk.addr),
		.wdata(lk.wdata), .ack(lk.ack), .err(lk.err), .rdata(lk.rdata), .state(lk.state));
	always #12.5 aclk = ~aclk;
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction : xs
	function automatic logic [31:0] exp_modes(input logic [15:0] m);
		return {27'h0, m[`SSB_BINNING_BIT], m[`SSB_SUBSAMP_BIT], m[`SSB_SLAVE_BIT], m[`SSB_TRIG_BIT],
			m[`SSB_SHUTTER_BIT]};
	endfunction : exp_modes
	task automatic tally_and_finish();
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (awvalid && awready) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		bready <= 1'b0;
	endtask : axi_write
	task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : axi_read
	task automatic wait_dev(input logic [2:0] d);
		for (int i = 0; i < 400 && dev_state !== d; i++)
			@(posedge aclk);
	endtask : wait_dev
	initial begin
		repeat (20000) @(posedge aclk);
		error_cnt++;
		tally_and_finish();
	end
	initial begin
		for (int r = 0; r < 3; r++) begin
			// Each round after the first resets a running sensor
			aresetn <= 1'b0;
			repeat (4) @(posedge aclk);
			aresetn <= 1'b1;
			@(posedge aclk);
			#1;
			check("state_after_reset", ssb_pkg::DS_OFF, dev_state);
			check("acq_after_reset", 32'h0, acquiring);
			seed = xs(seed);
			mode = (r == 0) ? `SSB_MODE_MASK : seed[15:0] & `SSB_MODE_MASK;
			col = (r == 0) ? 1'b0 : seed[16];
			w8 = (r == 0) ? 1'b1 : seed[17];
			axi_write(`SSB_R_MODE, {16'h0, mode});
			axi_write(`SSB_R_CTRL, {28'h0, w8, col, 2'b01});
			st = 32'h0;
			for (int i = 0; i < 200 && st[6] !== 1'b1; i++)
				axi_read(`SSB_R_STATUS, st, rs);
			check("bringup_state", ssb_pkg::DS_IDLE, dev_state);
			check("status_dev_state", ssb_pkg::DS_IDLE, st[5:3]);
			check("link_err", 32'h0, st[7]);
			check("word_depth", w8, word8);
			check("modes_idle", exp_modes(mode), {binning, subsample, slave, triggered, shutter_rolling});
			for (int k = 0; k < 3; k++) begin
				axi_write(`SSB_R_CTRL, {28'h0, w8, col, !k[0], 1'b1});
				wait_dev(k[0] ? ssb_pkg::DS_IDLE : ssb_pkg::DS_RUN);
				check("seq_state", k[0] ? ssb_pkg::DS_IDLE : ssb_pkg::DS_RUN, dev_state);
				check("acquiring", !k[0], acquiring);
				check("modes_kept", exp_modes(mode), {binning, subsample, slave, triggered, shutter_rolling});
			end
			axi_read(`SSB_R_MODE, st, rs);
			check("mode_readback", {16'h0, mode}, st);
			axi_read(4'hc, st, rs);
			check("unmapped_resp", `SSB_RESP_SLVERR, rs);
			check("unmapped_data", 32'h0, st);
		end
		tally_and_finish();
	end
endmodule : sensor_state_bringup_sequencer_test
`default_nettype wire
